// File: rtl/rlss_pkg.sv
// Shared constants of the rate and signal-loss setting selection block.
// Assumes a byte-wide register port fed by the two-wire serial host decoder.
package rlss_pkg;
    // Register offsets
    localparam logic [7:0] OFS_BW_A = 8'h06;
    localparam logic [7:0] OFS_BW_B = 8'h07;
    localparam logic [7:0] OFS_BW_C = 8'h08;
    localparam logic [7:0] OFS_BW_D = 8'h09;
    localparam logic [7:0] OFS_LOS_A = 8'h0A;
    localparam logic [7:0] OFS_LOS_B = 8'h0B;
    localparam logic [7:0] OFS_LOS_C = 8'h0C;
    localparam logic [7:0] OFS_LOS_D = 8'h0D;
    localparam logic [7:0] OFS_SEL_BW = 8'h0E;
    localparam logic [7:0] OFS_SEL_LOS = 8'h0F;
    localparam int RLSS_NUM_RW = 8;
    // Field layout
    localparam int ENABLE_BIT = 7;
    localparam int BW_W = 4;
    localparam int LOS_W = 7;
    // Reset values
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic PIN_HI_RESET = 1'b1;
    localparam logic PIN_LO_RESET = 1'b0;
    // Register slot chosen by the speed-select pins
    localparam logic [1:0] IDX_A = 2'h0;
    localparam logic [1:0] IDX_B = 2'h1;
    localparam logic [1:0] IDX_C = 2'h2;
    localparam logic [1:0] IDX_D = 2'h3;
endpackage

// File: rtl/rlss_sel_if.sv
// Carrier between the top and one setting selector.
// Assumes the top drives the slot index, settings and default codes.
`timescale 1ns/100ps
interface rlss_sel_if #(parameter int W = 4);
    logic [1:0] idx;
    logic [7:0] setting [4];
    logic [W-1:0] default_code [4];
    logic [W-1:0] applied;
    modport src (output idx, output setting, output default_code, input applied);
    modport mux (input idx, input setting, input default_code, output applied);
endinterface

// File: rtl/rlss_pin_sync.sv
// Three-stage synchroniser with agreement filter for one strap pin.
// Assumes the pin is asynchronous to core_clk_in.
`timescale 1ns/100ps
module rlss_pin_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    // Pin and filtered level
    input wire logic pin_in,
    output logic level_out
);
    logic ff1;
    logic ff2;
    logic ff3;
    wire agree = (ff2 == ff3);

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ff1 <= RESET_VAL;
            ff2 <= RESET_VAL;
            ff3 <= RESET_VAL;
            level_out <= RESET_VAL;
        end else begin
            ff1 <= pin_in;
            ff2 <= ff1;
            ff3 <= ff2;
            if (agree) begin
                level_out <= ff3;
            end
        end
    end

    a_sync_agree: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        (level_out != $past(level_out)) |-> ($past(ff2) == $past(ff3) && level_out == $past(ff3)))
        else $error("level changed without stage agreement");
endmodule

// File: rtl/rlss_setting_mux.sv
// Picks one of four settings and applies code or fixed default.
// Assumes idx is already synchronised to the core clock.
`timescale 1ns/100ps
module rlss_setting_mux
    import rlss_pkg::*;
#(
    parameter int W = 4
) (
    rlss_sel_if.mux sel_if
);
    wire [7:0] chosen = sel_if.setting[sel_if.idx];
    wire use_code = chosen[ENABLE_BIT];

    // enable bit picks stored code over default
    assign sel_if.applied = use_code ? chosen[W-1:0] : sel_if.default_code[sel_if.idx];
endmodule

// File: rtl/rlss_top.sv
// Top of the rate and signal-loss setting selection block.
// Assumes a serial host decoder presents byte register accesses on core_clk_in;
// unconnected speed-select pins are pulled to high=1, low=0 on the board.
`timescale 1ns/100ps
module rlss_top
    import rlss_pkg::*;
#(
    // Codes standing for the fixed defaults 2.2, 4.0, 6.5 and 11.0 GHz
    parameter logic [BW_W-1:0] BW_DEF_A = 4'h2,
    parameter logic [BW_W-1:0] BW_DEF_B = 4'h4,
    parameter logic [BW_W-1:0] BW_DEF_C = 4'h7,
    parameter logic [BW_W-1:0] BW_DEF_D = 4'hF,
    // Codes standing for the fixed defaults 15, 18 and 26 mVpp
    parameter logic [LOS_W-1:0] LOS_DEF_A = 7'h0F,
    parameter logic [LOS_W-1:0] LOS_DEF_B = 7'h12,
    parameter logic [LOS_W-1:0] LOS_DEF_CD = 7'h1A
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    // Speed-select pins
    input wire logic speed_select_pin_hi_in,
    input wire logic speed_select_pin_lo_in,
    // Register port from serial host decoder
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    // Applied settings to the analog core
    output logic [BW_W-1:0] applied_bw_code_out,
    output logic [LOS_W-1:0] applied_los_code_out
);
    logic [7:0] setting_reg [RLSS_NUM_RW];
    logic speed_select_pin_hi;
    logic speed_select_pin_lo;
    logic [BW_W-1:0] applied_bandwidth_readback;
    logic [LOS_W-1:0] applied_assert_level_readback;

    rlss_pin_sync #(.RESET_VAL(PIN_HI_RESET)) u_sync_hi (
        .core_clk_in(core_clk_in),
        .rst_b_in(rst_b_in),
        .pin_in(speed_select_pin_hi_in),
        .level_out(speed_select_pin_hi)
    );
    rlss_pin_sync #(.RESET_VAL(PIN_LO_RESET)) u_sync_lo (
        .core_clk_in(core_clk_in),
        .rst_b_in(rst_b_in),
        .pin_in(speed_select_pin_lo_in),
        .level_out(speed_select_pin_lo)
    );

    // Pin pair as {high, low}
    wire [1:0] pins = {speed_select_pin_hi, speed_select_pin_lo};
    wire pick_a = (pins == 2'h0);
    // high 0, low 1 pick B
    wire pick_b = (pins == 2'h1);
    wire pick_c = (pins == 2'h3);
    // high 1, low 0 or floating pick D
    wire [1:0] sel_idx = pick_a ? IDX_A :
                         pick_b ? IDX_B :
                         pick_c ? IDX_C : IDX_D;

    // Register write decode; read-only offsets fall outside the window
    wire wr_hit = reg_wr_in && (reg_addr_in >= OFS_BW_A) && (reg_addr_in <= OFS_LOS_D);
    wire [7:0] wr_ofs = reg_addr_in - OFS_BW_A;
    wire [2:0] wr_slot = wr_ofs[2:0];

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            for (int i = 0; i < RLSS_NUM_RW; i++) begin
                setting_reg[i] <= REG_RESET;
            end
        end else if (wr_hit) begin
            setting_reg[wr_slot] <= reg_wdata_in;
        end
    end

    wire [7:0] bandwidth_setting_a = setting_reg[0];
    wire [7:0] bandwidth_setting_b = setting_reg[1];
    wire [7:0] bandwidth_setting_c = setting_reg[2];
    wire [7:0] bandwidth_setting_d = setting_reg[3];
    wire [7:0] signal_loss_level_a = setting_reg[4];
    wire [7:0] signal_loss_level_b = setting_reg[5];
    wire [7:0] signal_loss_level_c = setting_reg[6];
    wire [7:0] signal_loss_level_d = setting_reg[7];

    rlss_sel_if #(.W(BW_W)) bw_if ();
    rlss_sel_if #(.W(LOS_W)) los_if ();

    // slot D also serves unconnected pins via board pulls
    assign bw_if.idx = sel_idx;
    assign bw_if.setting[0] = bandwidth_setting_a;
    assign bw_if.setting[1] = bandwidth_setting_b;
    assign bw_if.setting[2] = bandwidth_setting_c;
    assign bw_if.setting[3] = bandwidth_setting_d;
    assign bw_if.default_code[0] = BW_DEF_A;
    assign bw_if.default_code[1] = BW_DEF_B;
    assign bw_if.default_code[2] = BW_DEF_C;
    assign bw_if.default_code[3] = BW_DEF_D;

    // assert-level slot follows the same pin decode
    assign los_if.idx = sel_idx;
    assign los_if.setting[0] = signal_loss_level_a;
    assign los_if.setting[1] = signal_loss_level_b;
    assign los_if.setting[2] = signal_loss_level_c;
    assign los_if.setting[3] = signal_loss_level_d;
    // assert-level defaults, C and D share one
    assign los_if.default_code[0] = LOS_DEF_A;
    assign los_if.default_code[1] = LOS_DEF_B;
    assign los_if.default_code[2] = LOS_DEF_CD;
    assign los_if.default_code[3] = LOS_DEF_CD;

    rlss_setting_mux #(.W(BW_W)) u_bw_mux (
        .sel_if(bw_if.mux)
    );
    rlss_setting_mux #(.W(LOS_W)) u_los_mux (
        .sel_if(los_if.mux)
    );

    // Flopped so the analog core never sees a mux transient
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            applied_bandwidth_readback <= BW_DEF_D;
            applied_assert_level_readback <= LOS_DEF_CD;
        end else begin
            applied_bandwidth_readback <= bw_if.applied;
            applied_assert_level_readback <= los_if.applied;
        end
    end

    assign applied_bw_code_out = applied_bandwidth_readback;
    assign applied_los_code_out = applied_assert_level_readback;

    // read mux, upper bits of readback fields read zero
    wire rd_rw = (reg_addr_in >= OFS_BW_A) && (reg_addr_in <= OFS_LOS_D);
    wire [7:0] rd_data = rd_rw ? setting_reg[wr_slot] :
                         (reg_addr_in == OFS_SEL_BW) ? {4'h0, applied_bandwidth_readback} :
                         (reg_addr_in == OFS_SEL_LOS) ? {1'h0, applied_assert_level_readback} : 8'h00;

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            reg_rdata_out <= 8'h00;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in) begin
                reg_rdata_out <= rd_data;
            end
        end
    end

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    a_bw_b_code: assert property (
        (pins == 2'b01 && bandwidth_setting_b[ENABLE_BIT]) |=> applied_bw_code_out == $past(bandwidth_setting_b[3:0]))
        else $error("slot B enabled code not applied");
    a_bw_b_default: assert property (
        (pins == 2'b01 && !bandwidth_setting_b[ENABLE_BIT]) |=> applied_bw_code_out == BW_DEF_B)
        else $error("slot B default not applied");
    a_bw_c_select: assert property (
        (pins == 2'b11) |=> applied_bw_code_out ==
            ($past(bandwidth_setting_c[ENABLE_BIT]) ? $past(bandwidth_setting_c[3:0]) : BW_DEF_C))
        else $error("slot C bandwidth wrong");
    a_bw_d_select: assert property (
        (pins == 2'b10) |=> applied_bw_code_out ==
            ($past(bandwidth_setting_d[ENABLE_BIT]) ? $past(bandwidth_setting_d[3:0]) : BW_DEF_D))
        else $error("slot D bandwidth wrong");
    a_bw_a_select: assert property (
        (pins == 2'b00) |=> applied_bw_code_out ==
            ($past(bandwidth_setting_a[ENABLE_BIT]) ? $past(bandwidth_setting_a[3:0]) : BW_DEF_A))
        else $error("slot A bandwidth wrong");
    a_los_a_select: assert property (
        (pins == 2'b00) |=> applied_los_code_out ==
            ($past(signal_loss_level_a[ENABLE_BIT]) ? $past(signal_loss_level_a[6:0]) : LOS_DEF_A))
        else $error("slot A assert level wrong");
    a_los_b_select: assert property (
        (pins == 2'b01) |=> applied_los_code_out ==
            ($past(signal_loss_level_b[ENABLE_BIT]) ? $past(signal_loss_level_b[6:0]) : LOS_DEF_B))
        else $error("slot B assert level wrong");
    a_los_c_select: assert property (
        (pins == 2'b11) |=> applied_los_code_out ==
            ($past(signal_loss_level_c[ENABLE_BIT]) ? $past(signal_loss_level_c[6:0]) : LOS_DEF_CD))
        else $error("slot C assert level wrong");
    a_los_d_select: assert property (
        (pins == 2'b10) |=> applied_los_code_out ==
            ($past(signal_loss_level_d[ENABLE_BIT]) ? $past(signal_loss_level_d[6:0]) : LOS_DEF_CD))
        else $error("slot D assert level wrong");
    a_rd_bw_field: assert property (
        (reg_rd_in && reg_addr_in == OFS_SEL_BW) |=> reg_rvalid_out && reg_rdata_out == {4'h0, $past(applied_bw_code_out)})
        else $error("bandwidth readback wrong");
    a_rd_los_field: assert property (
        (reg_rd_in && reg_addr_in == OFS_SEL_LOS) |=> reg_rdata_out == {1'h0, $past(applied_los_code_out)})
        else $error("assert level readback wrong");
    a_ro_write_drop: assert property (
        (reg_wr_in && reg_addr_in == OFS_SEL_BW) |=> $stable(bandwidth_setting_a) && $stable(signal_loss_level_d))
        else $error("readback write disturbed settings");
    a_ro_los_write_drop: assert property (
        (reg_wr_in && reg_addr_in == OFS_SEL_LOS)
        |=> $stable(bandwidth_setting_b) && $stable(signal_loss_level_a))
        else $error("assert level readback write disturbed settings");
    a_rd_rvalid_pulse: assert property (
        reg_rvalid_out == $past(reg_rd_in))
        else $error("read valid not a one-cycle echo of the read strobe");

    a_bw_a_code: assert property (
        (pins == 2'h0 && bandwidth_setting_a[ENABLE_BIT])
        |=> applied_bw_code_out == $past(bandwidth_setting_a[3:0]))
        else $error("slot A enabled bandwidth code not applied");
    a_bw_a_default: assert property (
        (pins == 2'h0 && !bandwidth_setting_a[ENABLE_BIT])
        |=> applied_bw_code_out == BW_DEF_A)
        else $error("slot A bandwidth default not applied");
    a_bw_c_code: assert property (
        (pins == 2'h3 && bandwidth_setting_c[ENABLE_BIT])
        |=> applied_bw_code_out == $past(bandwidth_setting_c[3:0]))
        else $error("slot C enabled bandwidth code not applied");
    a_bw_c_default: assert property (
        (pins == 2'h3 && !bandwidth_setting_c[ENABLE_BIT])
        |=> applied_bw_code_out == BW_DEF_C)
        else $error("slot C bandwidth default not applied");
    a_bw_d_code: assert property (
        (pins == 2'h2 && bandwidth_setting_d[ENABLE_BIT])
        |=> applied_bw_code_out == $past(bandwidth_setting_d[3:0]))
        else $error("slot D enabled bandwidth code not applied");
    a_bw_d_default: assert property (
        (pins == 2'h2 && !bandwidth_setting_d[ENABLE_BIT])
        |=> applied_bw_code_out == BW_DEF_D)
        else $error("slot D bandwidth default not applied");

    a_los_a_code: assert property (
        (pins == 2'h0 && signal_loss_level_a[ENABLE_BIT])
        |=> applied_los_code_out == $past(signal_loss_level_a[6:0]))
        else $error("slot A enabled assert level not applied");
    a_los_a_default: assert property (
        (pins == 2'h0 && !signal_loss_level_a[ENABLE_BIT])
        |=> applied_los_code_out == LOS_DEF_A)
        else $error("slot A assert level default not applied");
    a_los_b_code: assert property (
        (pins == 2'h1 && signal_loss_level_b[ENABLE_BIT])
        |=> applied_los_code_out == $past(signal_loss_level_b[6:0]))
        else $error("slot B enabled assert level not applied");
    a_los_b_default: assert property (
        (pins == 2'h1 && !signal_loss_level_b[ENABLE_BIT])
        |=> applied_los_code_out == LOS_DEF_B)
        else $error("slot B assert level default not applied");
    a_los_c_code: assert property (
        (pins == 2'h3 && signal_loss_level_c[ENABLE_BIT])
        |=> applied_los_code_out == $past(signal_loss_level_c[6:0]))
        else $error("slot C enabled assert level not applied");
    a_los_c_default: assert property (
        (pins == 2'h3 && !signal_loss_level_c[ENABLE_BIT])
        |=> applied_los_code_out == LOS_DEF_CD)
        else $error("slot C assert level default not applied");
    a_los_d_code: assert property (
        (pins == 2'h2 && signal_loss_level_d[ENABLE_BIT])
        |=> applied_los_code_out == $past(signal_loss_level_d[6:0]))
        else $error("slot D enabled assert level not applied");
    a_los_d_default: assert property (
        (pins == 2'h2 && !signal_loss_level_d[ENABLE_BIT])
        |=> applied_los_code_out == LOS_DEF_CD)
        else $error("slot D assert level default not applied");

    // Extreme codes must pass unchanged, no clamping
    a_los_min_a: assert property (
        (pins == 2'h0 && signal_loss_level_a == 8'h80)
        |=> applied_los_code_out == 7'h00)
        else $error("minimum assert level code altered");
    a_los_max_b: assert property (
        (pins == 2'h1 && signal_loss_level_b == 8'hFF)
        |=> applied_los_code_out == 7'h7F)
        else $error("maximum assert level code altered");
    a_los_min_c: assert property (
        (pins == 2'h3 && signal_loss_level_c == 8'h80)
        |=> applied_los_code_out == 7'h00)
        else $error("minimum assert level code altered in slot C");
    a_los_max_d: assert property (
        (pins == 2'h2 && signal_loss_level_d == 8'hFF)
        |=> applied_los_code_out == 7'h7F)
        else $error("maximum assert level code altered in slot D");

    // A filtered level may only take a pin value that stood for two samples
    a_pin_hi_filter: assert property (
        (speed_select_pin_hi != $past(speed_select_pin_hi))
        |-> (speed_select_pin_hi == $past(speed_select_pin_hi_in, 4) &&
            $past(speed_select_pin_hi_in, 3) == $past(speed_select_pin_hi_in, 4)))
        else $error("high pin level changed before the filter agreed");
    a_pin_lo_filter: assert property (
        (speed_select_pin_lo != $past(speed_select_pin_lo))
        |-> (speed_select_pin_lo == $past(speed_select_pin_lo_in, 4) &&
            $past(speed_select_pin_lo_in, 3) == $past(speed_select_pin_lo_in, 4)))
        else $error("low pin level changed before the filter agreed");
endmodule

// File: dv/rlss_host_model.sv
// Host side model: byte register master and speed-select pin driver.
// Assumes the block takes requests on the rising edge of core_clk_in.
`timescale 1ns/100ps
module rlss_host_model (
    // Clock
    input wire logic core_clk_in,
    // Register port
    output logic [7:0] reg_addr_out,
    output logic reg_wr_out,
    output logic [7:0] reg_wdata_out,
    output logic reg_rd_out,
    input wire logic [7:0] reg_rdata_in,
    input wire logic reg_rvalid_in,
    // Speed-select pins, reset level is the unconnected strap
    output logic pin_hi_out,
    output logic pin_lo_out
);
    initial begin
        reg_addr_out = 8'h00;
        reg_wr_out = 1'b0;
        reg_wdata_out = 8'h00;
        reg_rd_out = 1'b0;
        pin_hi_out = 1'b1;
        pin_lo_out = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        reg_addr_out <= a;
        reg_wdata_out <= d;
        reg_wr_out <= 1'b1;
        @(posedge core_clk_in);
        reg_wr_out <= 1'b0;
        // Released data must not look like the last byte
        reg_wdata_out <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(posedge core_clk_in);
        reg_addr_out <= a;
        reg_rd_out <= 1'b1;
        @(posedge core_clk_in);
        reg_rd_out <= 1'b0;
        #1;
        ok = reg_rvalid_in;
        d = reg_rdata_in;
    endtask
    task automatic pins(input logic [1:0] p);
        @(posedge core_clk_in);
        pin_hi_out <= p[1];
        pin_lo_out <= p[0];
    endtask
endmodule

// File: dv/rlss_top_tb.sv
// Self-checking bench: register model against the selection block.
// Assumes the host model drives every register port and pin input; the bench drives clock and reset.
`timescale 1ns/100ps
module rlss_top_tb;
    import rlss_pkg::*;
    logic core_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic pin_hi, pin_lo, wr, rd, rvalid;
    logic [7:0] addr, wdata, rdata;
    logic [3:0] applied_bw;
    logic [6:0] applied_los;
    int n_mismatch = 0;
    int checked = 0;
    int seed = 95429;
    int pinsel = 2;
    int slot_of [4] = '{0, 1, 3, 2};
    logic [6:0] bw_def [4] = '{7'h02, 7'h04, 7'h07, 7'h0F};
    logic [6:0] los_def [4] = '{7'h0F, 7'h12, 7'h1A, 7'h1A};
    logic [7:0] mregs [8] = '{default: 8'h00};
    logic [7:0] v;
    always #5 core_clk_in = ~core_clk_in;
    rlss_top DUT (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .speed_select_pin_hi_in(pin_hi),
        .speed_select_pin_lo_in(pin_lo), .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdata),
        .reg_rd_in(rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .applied_bw_code_out(applied_bw), .applied_los_code_out(applied_los));
    rlss_host_model HOST (.core_clk_in(core_clk_in), .reg_addr_out(addr), .reg_wr_out(wr),
        .reg_wdata_out(wdata), .reg_rd_out(rd), .reg_rdata_in(rdata), .reg_rvalid_in(rvalid),
        .pin_hi_out(pin_hi), .pin_lo_out(pin_lo));
    task automatic cmp_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmp_code(input string nm, input logic [6:0] e, input logic [6:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
        logic [7:0] d;
        logic ok;
        HOST.rd(a, d, ok);
        cmp_reg("read valid", 8'h01, {7'h00, ok});
        cmp_reg(nm, e, d);
    endtask
    function automatic logic [6:0] exp_bw(input int s);
        return mregs[s][7] ? {3'h0, mregs[s][3:0]} : bw_def[s];
    endfunction
    function automatic logic [6:0] exp_los(input int s);
        return mregs[4 + s][7] ? mregs[4 + s][6:0] : los_def[s];
    endfunction
    task automatic check_all();
        int s;
        logic [6:0] eb;
        logic [6:0] el;
        s = slot_of[pinsel];
        eb = exp_bw(s);
        el = exp_los(s);
        @(posedge core_clk_in);
        #1;
        cmp_code("bw code", eb, {3'h0, applied_bw});
        cmp_code("los code", el, applied_los);
        rdc(OFS_SEL_BW, {1'b0, eb}, "bw readback");
        rdc(OFS_SEL_LOS, {1'b0, el}, "los readback");
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge core_clk_in);
        rst_b_in <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rdc(OFS_BW_A + 8'(i), 8'h00, "reset reg");
        end
        check_all();
        // Rounds: enables clear, enables set with extreme assert-level codes, random
        for (int r = 0; r < 3; r++) begin
            for (int i = 0; i < 8; i++) begin
                v = 8'($random(seed));
                if (r < 2) v[7] = r[0];
                if (r == 1 && i >= 4) v[6:0] = i[0] ? 7'h7F : 7'h00;
                HOST.wr(OFS_BW_A + 8'(i), v);
                mregs[i] = v;
                rdc(OFS_BW_A + 8'(i), v, "rw reg");
            end
            for (int p = 0; p < 4; p++) begin
                HOST.pins(2'(p));
                repeat (4) @(posedge core_clk_in);
                #1;
                // Three stages plus agreement keep the old choice for four edges
                cmp_code("bw early", exp_bw(slot_of[pinsel]), {3'h0, applied_bw});
                cmp_code("los early", exp_los(slot_of[pinsel]), applied_los);
                @(posedge core_clk_in);
                #1;
                cmp_code("bw on time", exp_bw(slot_of[p]), {3'h0, applied_bw});
                repeat (2) @(posedge core_clk_in);
                pinsel = p;
                check_all();
            end
        end
        HOST.wr(OFS_SEL_BW, 8'hFF);
        HOST.wr(OFS_SEL_LOS, 8'hFF);
        check_all();
        for (int i = 0; i < 8; i++) begin
            rdc(OFS_BW_A + 8'(i), mregs[i], "kept reg");
        end
        rdc(8'h3C, 8'h00, "unmapped read");
        wrap_up();
    end
    initial begin
        #100000;
        n_mismatch++;
        wrap_up();
    end
endmodule
